/* File: inc/rpc_pkg.sv */
/*
  shared constants, state codes and carrier structs of the real time clock block.
  assumes a single 200 MHz clock and synchronous oscillator sample inputs.
*/
// Overview of operation
// - counting edges come from the main or the low-power oscillator input.
// - the basic tick comes from a 20-bit down-divider after a fixed divide by 64.
// - at each tick the divider reloads from the 20-bit reload value, which sets the period.
// - when enabled, a tick interrupt request is raised once per basic tick period.
// - when enabled, a request is raised every n ticks and offered to the external interrupt.
// - a 32-bit time counter can be preloaded by software and advances on every basic tick.
// - an alarm request is raised when the time counter equals the 32-bit alarm value.
// - prescaler, divider and counter together form a 58-bit timer for long-term measurement.
// - tick and alarm requests can be routed to a wake-capable fast external interrupt.
// - with the power-down wake bit set, a routed request wakes the chip from power down.
// - with the oscillator-off bit set, the clock oscillator stops on entry to power down.
// - power down with the block disabled stops both the main and the low-power oscillator.
// - a 32 kHz oscillation seen after reset drives the block, main stops in power down.
// - with no 32 kHz input the main oscillator drives the block and stays on if enabled and the oscillator-off bit is clear.
// - of the block's registers only the time counter can be written; counter, divider and prescaler read back on longTimer.
`default_nettype none
package rpc_pkg;
  localparam int PRE_W = 6;
  localparam logic [PRE_W-1:0] PRE_LAST = 6'h3f;
  localparam int DIV_W = 20;
  localparam int CNT_W = 32;
  localparam int NT_W = 16;
  localparam int LONG_W = 58;
  localparam logic [DIV_W-1:0] DIV_RST = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h00000000;
  localparam logic [NT_W-1:0] NT_RST = 16'h0000;
  localparam int DETECT_CYC_DEF = 8192;
  localparam logic [1:0] EXT_TICK = 2'h0;
  localparam logic [1:0] EXT_NTICK = 2'h1;
  localparam logic [1:0] EXT_ALARM = 2'h2;
  localparam logic [1:0] EXT_ANY = 2'h3;

  typedef enum logic [2:0] {
    SRC_DETECT = 3'b001,
    SRC_MAIN = 3'b010,
    SRC_LP = 3'b100
  } rpc_src_t;

  typedef struct packed {
    logic enable;
    logic tickIrqEn;
    logic nTickIrqEn;
    logic alarmIrqEn;
    logic oscSwitchOffBit;
    logic powerdownWakeConfig;
    logic [1:0] extInterruptSourceSelect;
  } rpc_cfg_t;

  typedef struct packed {
    logic tick;
    logic nTick;
    logic alarm;
  } rpc_irq_t;
endpackage
`default_nettype wire

/* File: tb/test_rpc_top.sv */
/*
  self-checking bench for the real time clock block: source detect, divider chain,
  time counter, alarm, n-tick, pending flags, external select, wake and oscillator off.
  assumes the design files and rpc_pkg are compiled first; oscillators are driven as
  sampled levels with one low cycle between rising edges.
*/
`default_nettype none
module test_rpc_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rpc_pkg::*;

  localparam int CEIL = 10000;
  logic clk, rst, mainOsc, lpOsc, powerDown, counterWrite, lpMode;
  rpc_cfg_t cfg;
  rpc_irq_t irqAck, irqPending;
  logic [DIV_W-1:0] reload;
  logic [NT_W-1:0] nTicks;
  logic [CNT_W-1:0] alarm, wrData, timeCount;
  logic [LONG_W-1:0] longTimer;
  logic extReq, wakeReq, lpSel, mainOff, lpOff;
  int numErrors, testsRun, cycles;

  // short detect window keeps the run brief
  rpc_top #(.DETECT_CYC(16)) dut (
    .clk(clk),
    .rst(rst),
    .mainOscInput(mainOsc),
    .lowPowerOscInput(lpOsc),
    .clockControlRegister(cfg),
    .powerDown(powerDown),
    .tickPeriodReload(reload),
    .nTickCount(nTicks),
    .alarmValue(alarm),
    .counterWrite(counterWrite),
    .counterWriteData(wrData),
    .irqAck(irqAck),
    .irqPending(irqPending),
    .timeCount(timeCount),
    .longTimer(longTimer),
    .extInterruptRequest(extReq),
    .wakeRequest(wakeReq),
    .lpSelected(lpSel),
    .mainOscOff(mainOff),
    .lpOscOff(lpOff)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      numErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d, checks %0d", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // sample after the edge's updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one counted edge needs a low cycle after it, so two clocks per edge
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (lpMode) lpOsc <= 1'b1;
      else mainOsc <= 1'b1;
      @(posedge clk);
      lpOsc <= 1'b0;
      mainOsc <= 1'b0;
    end
    wait_cyc(4);
  endtask

  task automatic ack_pulse(input rpc_irq_t a);
    @(posedge clk) irqAck <= a;
    @(posedge clk) irqAck <= '0;
    wait_cyc(1);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      numErrors++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  initial
  begin
    rst = 1'b1;
    mainOsc = 1'b0;
    lpOsc = 1'b0;
    lpMode = 1'b0;
    powerDown = 1'b0;
    counterWrite = 1'b0;
    cfg = '0;
    irqAck = '0;
    reload = 20'h00001;
    nTicks = 16'h0003;
    alarm = 32'h00000100;
    wrData = 32'h000000fe;
    numErrors = 0;
    testsRun = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(20);
    chk({timeCount, 3'(irqPending), lpSel}, 64'h0);
    @(posedge clk) powerDown <= 1'b1;
    wait_cyc(1);
    chk({mainOff, lpOff}, 2'b11);
    @(posedge clk) cfg.enable <= 1'b1;
    wait_cyc(1);
    chk({mainOff, lpOff}, 2'b01);
    @(posedge clk) cfg.oscSwitchOffBit <= 1'b1;
    wait_cyc(1);
    chk(mainOff, 1'b1);
    @(posedge clk)
    begin
      powerDown <= 1'b0;
      cfg.oscSwitchOffBit <= 1'b0;
      cfg.tickIrqEn <= 1'b1;
      cfg.alarmIrqEn <= 1'b1;
      cfg.powerdownWakeConfig <= 1'b1;
      counterWrite <= 1'b1;
    end
    @(posedge clk) counterWrite <= 1'b0;
    wait_cyc(0);
    chk(timeCount, 32'hfe);
    edges(10);
    chk(longTimer, {32'hfe, 20'h1, 6'ha});
    edges(118);
    chk({timeCount, 3'(irqPending)}, {32'hff, 3'b100});
    ack_pulse(3'b100);
    chk(irqPending.tick, 1'b0);
    edges(128);
    chk({timeCount, 3'(irqPending)}, {32'h100, 3'b101});
    // select codes: tick, n-tick, alarm, any
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk) cfg.extInterruptSourceSelect <= s[1:0];
      wait_cyc(1);
      chk(extReq, s != 1);
    end
    @(posedge clk) powerDown <= 1'b1;
    wait_cyc(2);
    chk(wakeReq, 1'b1);
    @(posedge clk) cfg.extInterruptSourceSelect <= EXT_NTICK;
    wait_cyc(2);
    chk(wakeReq, 1'b0);
    @(posedge clk) powerDown <= 1'b0;
    ack_pulse(3'b101);
    @(posedge clk) cfg.nTickIrqEn <= 1'b1;
    edges(256);
    chk(irqPending.nTick, 1'b0);
    edges(128);
    chk(irqPending.nTick, 1'b1);
    ack_pulse(3'b010);
    chk(irqPending.nTick, 1'b0);
    edges(384);
    chk(irqPending.nTick, 1'b1);
    // second reset with the low-power oscillator present
    @(posedge clk)
    begin
      rst <= 1'b1;
      reload <= 20'h00000;
    end
    lpMode = 1'b1;
    wait_cyc(3);
    @(posedge clk) rst <= 1'b0;
    edges(2);
    chk(lpSel, 1'b1);
    edges(62);
    chk(timeCount, 32'h0);
    // last edge of the period meets a counter write and a tick ack
    @(posedge clk)
    begin
      lpOsc <= 1'b1;
      counterWrite <= 1'b1;
      irqAck <= 3'b100;
    end
    @(posedge clk)
    begin
      lpOsc <= 1'b0;
      counterWrite <= 1'b0;
      irqAck <= '0;
    end
    wait_cyc(0);
    chk({timeCount, irqPending.tick}, {32'hff, 1'b1});
    edges(1);
    chk(longTimer, {32'hff, 20'h0, 6'h1});
    @(posedge clk) powerDown <= 1'b1;
    wait_cyc(1);
    chk({mainOff, lpOff}, 2'b10);
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: verilog/rpc_divider.sv */
/*
  fixed divide-by-64 stage followed by the 20-bit reloadable down-divider.
  assumes srcEdge is a one-cycle pulse per counting clock edge.
*/
`default_nettype none
module rpc_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic srcEdge,
  input wire logic [rpc_pkg::DIV_W-1:0] tickPeriodReload,
  output logic tick,
  output logic [rpc_pkg::PRE_W-1:0] preCount,
  output logic [rpc_pkg::DIV_W-1:0] divCount
);
  import rpc_pkg::*;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic preCarry;

  assign preCarry = srcEdge & (pre_q == PRE_LAST);

  always_comb
  begin
    pre_d = pre_q;
    div_d = div_q;
    if (!enable)
    begin
      pre_d = '0;
      div_d = tickPeriodReload;
    end
    else
    begin
      if (srcEdge)
        pre_d = pre_q + 6'h1;
      if (preCarry)
        div_d = (div_q == DIV_RST) ? tickPeriodReload : div_q - 20'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_q <= '0;
      div_q <= DIV_RST;
    end
    else
    begin
      pre_q <= pre_d;
      div_q <= div_d;
    end
  end

  // period is reload+1 prescaled edges
  assign tick = enable & preCarry & (div_q == DIV_RST);
  assign preCount = pre_q;
  assign divCount = div_q;
endmodule
`default_nettype wire

/* File: verilog/rpc_osc_ctrl.sv */
/*
  oscillator source detection, source edge extraction and power-down oscillator switch-off.
  assumes both oscillator inputs are sampled levels synchronous to clk.
*/
`default_nettype none
module rpc_osc_ctrl #(
  parameter int DETECT_CYC = rpc_pkg::DETECT_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mainOscInput,
  input wire logic lowPowerOscInput,
  input wire logic enable,
  input wire logic oscSwitchOffBit,
  input wire logic powerDown,
  output logic srcEdge,
  output logic lpSelected,
  output logic mainOscOff,
  output logic lpOscOff
);
  import rpc_pkg::*;
  rpc_src_t src_q, src_d;
  logic [31:0] detCnt_q, detCnt_d;
  logic mainPrev_q, lpPrev_q;
  logic mainRise, lpRise, selOff;

  assign mainRise = mainOscInput & ~mainPrev_q;
  assign lpRise = lowPowerOscInput & ~lpPrev_q;

  always_comb
  begin
    src_d = src_q;
    detCnt_d = detCnt_q;
    unique case (src_q)
      SRC_DETECT:
      begin
        detCnt_d = detCnt_q + 32'h1;
        if (lpRise)
          src_d = SRC_LP;
        else if (detCnt_q == 32'(DETECT_CYC - 1))
          src_d = SRC_MAIN;
      end
      SRC_MAIN: src_d = SRC_MAIN;
      SRC_LP: src_d = SRC_LP;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      src_q <= SRC_DETECT;
      detCnt_q <= 32'h0;
      mainPrev_q <= 1'b0;
      lpPrev_q <= 1'b0;
    end
    else
    begin
      src_q <= src_d;
      detCnt_q <= detCnt_d;
      mainPrev_q <= mainOscInput;
      lpPrev_q <= lowPowerOscInput;
    end
  end

  assign lpSelected = (src_q == SRC_LP);
  // the oscillator that feeds the block stops when it is switched off
  assign selOff = powerDown & (oscSwitchOffBit | ~enable);
  assign mainOscOff = powerDown & (lpSelected | ~enable | oscSwitchOffBit);
  assign lpOscOff = powerDown & (~lpSelected | selOff);
  // no counting edges until the source is known
  assign srcEdge = ~selOff
    & ((src_q == SRC_LP) ? lpRise : (src_q == SRC_MAIN) & mainRise);
endmodule
`default_nettype wire

/* File: verilog/rpc_top.sv */
/*
  real time clock: source select, prescaler, time counter, alarm, pending requests, wake.
  assumes all control ports are synchronous to clk and acks are one-cycle pulses.
*/
`default_nettype none
module rpc_top #(
  parameter int DETECT_CYC = rpc_pkg::DETECT_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mainOscInput,
  input wire logic lowPowerOscInput,
  input wire rpc_pkg::rpc_cfg_t clockControlRegister,
  input wire logic powerDown,
  input wire logic [rpc_pkg::DIV_W-1:0] tickPeriodReload,
  input wire logic [rpc_pkg::NT_W-1:0] nTickCount,
  input wire logic [rpc_pkg::CNT_W-1:0] alarmValue,
  input wire logic counterWrite,
  input wire logic [rpc_pkg::CNT_W-1:0] counterWriteData,
  input wire rpc_pkg::rpc_irq_t irqAck,
  output var rpc_pkg::rpc_irq_t irqPending,
  output logic [rpc_pkg::CNT_W-1:0] timeCount,
  output logic [rpc_pkg::LONG_W-1:0] longTimer,
  output logic extInterruptRequest,
  output logic wakeRequest,
  output logic lpSelected,
  output logic mainOscOff,
  output logic lpOscOff
);
  import rpc_pkg::*;
  rpc_cfg_t cfg;
  logic srcEdge, tick, nTickEvt, matchNow, alarmRise;
  logic [PRE_W-1:0] preCount;
  logic [DIV_W-1:0] divCount;
  logic [NT_W-1:0] nTickLoad;
  rpc_irq_t pend_q, pend_d, irqSet;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [NT_W-1:0] nCnt_q, nCnt_d;
  logic match_q, wake_q, wake_d, extSel;

  assign cfg = clockControlRegister;

  rpc_osc_ctrl #(
    .DETECT_CYC(DETECT_CYC)
  ) u_osc (
    .clk(clk),
    .rst(rst),
    .mainOscInput(mainOscInput),
    .lowPowerOscInput(lowPowerOscInput),
    .enable(cfg.enable),
    .oscSwitchOffBit(cfg.oscSwitchOffBit),
    .powerDown(powerDown),
    .srcEdge(srcEdge),
    .lpSelected(lpSelected),
    .mainOscOff(mainOscOff),
    .lpOscOff(lpOscOff)
  );

  rpc_divider u_div (
    .clk(clk),
    .rst(rst),
    .enable(cfg.enable),
    .srcEdge(srcEdge),
    .tickPeriodReload(tickPeriodReload),
    .tick(tick),
    .preCount(preCount),
    .divCount(divCount)
  );

  // time counter; a write that meets a tick still counts that tick
  always_comb
  begin
    cnt_d = cnt_q;
    if (counterWrite)
      cnt_d = counterWriteData + (tick ? 32'h1 : 32'h0);
    else if (tick)
      cnt_d = cnt_q + 32'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= CNT_RST;
    else
      cnt_q <= cnt_d;
  end

  // n-tick counter; n of zero behaves as one
  assign nTickLoad = (nTickCount == NT_RST) ? NT_RST : nTickCount - 16'h1;
  assign nTickEvt = tick & cfg.nTickIrqEn & (nCnt_q == NT_RST);

  always_comb
  begin
    nCnt_d = nCnt_q;
    if (!cfg.nTickIrqEn)
      nCnt_d = nTickLoad;
    else if (nTickEvt)
      nCnt_d = nTickLoad;
    else if (tick)
      nCnt_d = nCnt_q - 16'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      nCnt_q <= NT_RST;
    else
      nCnt_q <= nCnt_d;
  end

  // alarm fires once on reaching equality, not for every cycle it stays equal
  assign matchNow = (cnt_q == alarmValue);
  assign alarmRise = matchNow & ~match_q;

  assign irqSet.tick = tick & cfg.tickIrqEn;
  assign irqSet.nTick = nTickEvt;
  assign irqSet.alarm = alarmRise & cfg.alarmIrqEn;

  // set beats ack so an event in the ack cycle is kept
  always_comb
  begin
    pend_d = (pend_q & ~irqAck) | irqSet;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_q <= '0;
      match_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_d;
      match_q <= matchNow;
    end
  end

  always_comb
  begin
    extSel = 1'b0;
    unique case (cfg.extInterruptSourceSelect)
      EXT_TICK: extSel = pend_q.tick;
      EXT_NTICK: extSel = pend_q.nTick;
      EXT_ALARM: extSel = pend_q.alarm;
      EXT_ANY: extSel = |pend_q;
    endcase
  end

  // wake is registered so the power controller sees a clean level
  always_comb
  begin
    wake_d = powerDown & cfg.powerdownWakeConfig & extSel;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wake_q <= 1'b0;
    else
      wake_q <= wake_d;
  end

  assign irqPending = pend_q;
  assign timeCount = cnt_q;
  assign longTimer = {cnt_q, divCount, preCount};
  assign extInterruptRequest = extSel;
  assign wakeRequest = wake_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_tick_pending: assert property (
    tick && cfg.tickIrqEn |=> irqPending.tick)
    else $error("tick request not pending after tick");

  chk_count_advance: assert property (
    tick && !counterWrite |=> timeCount == $past(timeCount) + 32'h1)
    else $error("time counter did not advance on tick");

  chk_write_tick: assert property (
    counterWrite && tick |=> timeCount == $past(counterWriteData) + 32'h1)
    else $error("tick lost on counter write");

  chk_count_still: assert property (
    !tick && !counterWrite |=> $stable(timeCount))
    else $error("time counter moved without tick");

  chk_alarm_set: assert property (
    cfg.alarmIrqEn && timeCount == alarmValue && !match_q |=> irqPending.alarm)
    else $error("alarm request missing on match");

  chk_pending_hold: assert property (
    irqPending.alarm && !irqAck.alarm |=> irqPending.alarm)
    else $error("alarm pending dropped without ack");

  chk_ntick_reload: assert property (
    nTickEvt && cfg.nTickIrqEn |=> nCnt_q == $past(nTickLoad) && irqPending.nTick)
    else $error("n-tick counter did not restart");

  chk_div_reload: assert property (
    tick |=> divCount == $past(tickPeriodReload))
    else $error("divider did not reload after tick");

  chk_osc_disabled: assert property (
    powerDown && !cfg.enable |-> mainOscOff && lpOscOff)
    else $error("oscillators left running while disabled");

  chk_lp_main_off: assert property (
    powerDown && lpSelected |-> mainOscOff)
    else $error("main oscillator running with low-power source");

  chk_wake_cause: assert property (
    wakeRequest |-> $past(powerDown) && $past(cfg.powerdownWakeConfig))
    else $error("wake without power-down wake configuration");

  chk_ext_route: assert property (
    cfg.extInterruptSourceSelect == EXT_ALARM |-> extInterruptRequest == irqPending.alarm)
    else $error("alarm not routed to external interrupt");

  chk_pre_step: assert property (
    cfg.enable && srcEdge |=> preCount == $past(preCount) + 6'h1)
    else $error("prescaler did not step on counting edge");

  chk_pre_still: assert property (
    cfg.enable && !srcEdge |=> $stable(preCount))
    else $error("prescaler moved without counting edge");

  chk_div_idle: assert property (
    !cfg.enable |=> preCount == 6'h0 && divCount == $past(tickPeriodReload))
    else $error("divider chain not parked while disabled");

  chk_div_step: assert property (
    cfg.enable && srcEdge && preCount == PRE_LAST && divCount != DIV_RST
      |=> divCount == $past(divCount) - 20'h1)
    else $error("divider did not step on prescaler wrap");

  chk_div_hold: assert property (
    cfg.enable && !(srcEdge && preCount == PRE_LAST) |=> $stable(divCount))
    else $error("divider moved without prescaler wrap");

  chk_tick_point: assert property (
    tick |-> srcEdge && preCount == PRE_LAST && divCount == DIV_RST)
    else $error("tick outside the end of the period");

  chk_ntick_step: assert property (
    tick && cfg.nTickIrqEn && nCnt_q != NT_RST |=> nCnt_q == $past(nCnt_q) - 16'h1)
    else $error("n-tick counter did not step on tick");

  chk_ntick_load: assert property (
    !cfg.nTickIrqEn |=> nCnt_q == $past(nTickLoad))
    else $error("n-tick counter not preset while disabled");

  chk_ntick_quiet: assert property (
    cfg.nTickIrqEn && !tick |=> $stable(nCnt_q))
    else $error("n-tick counter moved without tick");

  chk_tick_ack: assert property (
    irqAck.tick && !irqSet.tick |=> !irqPending.tick)
    else $error("tick request not cleared by ack");

  chk_ntick_ack: assert property (
    irqAck.nTick && !irqSet.nTick |=> !irqPending.nTick)
    else $error("n-tick request not cleared by ack");

  chk_alarm_ack: assert property (
    irqAck.alarm && !irqSet.alarm |=> !irqPending.alarm)
    else $error("alarm request not cleared by ack");

  chk_tick_hold: assert property (
    irqPending.tick && !irqAck.tick |=> irqPending.tick)
    else $error("tick pending dropped without ack");

  chk_ntick_hold: assert property (
    irqPending.nTick && !irqAck.nTick |=> irqPending.nTick)
    else $error("n-tick pending dropped without ack");

  chk_set_wins: assert property (
    irqAck.tick && irqSet.tick |=> irqPending.tick)
    else $error("tick lost to a coincident ack");

  chk_lp_edges: assert property (
    lpSelected && srcEdge |-> lowPowerOscInput)
    else $error("counting edge not from low-power input");

  chk_main_edges: assert property (
    !lpSelected && srcEdge |-> mainOscInput)
    else $error("counting edge not from main input");

  chk_osc_stop: assert property (
    powerDown && cfg.oscSwitchOffBit |-> !srcEdge)
    else $error("counting with oscillator switched off");

  chk_src_kept: assert property (
    lpSelected |=> lpSelected)
    else $error("low-power source lost without reset");

  chk_main_kept: assert property (
    powerDown && !lpSelected && cfg.enable && !cfg.oscSwitchOffBit |-> !mainOscOff)
    else $error("main oscillator stopped while it feeds the block");

  chk_wake_set: assert property (
    powerDown && cfg.powerdownWakeConfig && extInterruptRequest |=> wakeRequest)
    else $error("wake missing for routed request");

  chk_ext_tick: assert property (
    cfg.extInterruptSourceSelect == EXT_TICK |-> extInterruptRequest == irqPending.tick)
    else $error("tick not routed to external interrupt");

  chk_ext_ntick: assert property (
    cfg.extInterruptSourceSelect == EXT_NTICK |-> extInterruptRequest == irqPending.nTick)
    else $error("n-tick not routed to external interrupt");

  chk_ext_any: assert property (
    cfg.extInterruptSourceSelect == EXT_ANY |-> extInterruptRequest == (|irqPending))
    else $error("combined request not routed to external interrupt");

  cov_set_wins: cover property (irqAck.tick && irqSet.tick);
  cov_tick: cover property (tick ##1 irqPending.tick);
  cov_alarm: cover property (alarmRise && cfg.alarmIrqEn);
  cov_ntick: cover property (nTickEvt);
  cov_wake: cover property (powerDown ##1 wakeRequest);
endmodule
`default_nettype wire
